// ==== rtl/exec_pkg.sv ====
package exec_pkg;

  localparam int WORD_W = 9;
  localparam int NIB_W = 4;
  localparam int PAGE_W = 4;
  localparam int OFS_W = 7;
  localparam int PC_W = PAGE_W + OFS_W;
  localparam int DEPTH = 4;
  localparam int SP_W = 2;

  // Instruction words; the page field sits in the low nibble where one exists
  localparam logic [WORD_W-1:0] OPC_NOP = 9'h000;
  localparam logic [WORD_W-1:0] OPC_BEGIN_CONV = 9'h081;
  localparam logic [WORD_W-1:0] OPC_ACC_TO_C = 9'h082;
  localparam logic [WORD_W-1:0] OPC_SKIP_DONE = 9'h043;
  localparam logic [WORD_W-1:0] OPC_RES_HIGH = 9'h088;
  localparam logic [WORD_W-1:0] OPC_RES_LOW = 9'h089;
  localparam logic [WORD_W-1:0] OPC_JUMP_IDX = 9'h010;
  localparam logic [WORD_W-1:0] OPC_CALL_IDX = 9'h050;
  localparam logic [WORD_W-1:0] OPG_TABLE = 9'h090;
  localparam logic [WORD_W-1:0] OPG_JUMP = 9'h030;
  localparam logic [WORD_W-1:0] OPG_CALL = 9'h070;
  localparam logic [WORD_W-1:0] PAGE_MASK = 9'h1f0;

  // Table pages are 12..15: the top two page bits are forced high
  localparam logic [1:0] TBL_PAGE_TOP = 2'h3;
  localparam int TBL_PAGE_LO_W = 2;
  localparam int TBL_D_W = 3;
  localparam int TBL_HI_MSB = 7;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [SP_W-1:0] SP_RESET = 2'h0;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;

  typedef enum logic [3:0] {
    OP_NOP, OP_BEGIN_CONV, OP_ACC_TO_C, OP_SKIP_DONE, OP_RES_HIGH, OP_RES_LOW,
    OP_TABLE, OP_JUMP, OP_JUMP_IDX, OP_CALL, OP_CALL_IDX, OP_OTHER
  } op_t;

  typedef enum logic [2:0] {
    ST_FETCH, ST_EXEC, ST_FETCH2, ST_EXEC2,
    ST_TBL_ADDR, ST_TBL_DATA, ST_RESTORE, ST_RESTORE2
  } state_t;

  typedef struct packed {
    state_t st;
    op_t op;
    logic [PAGE_W-1:0] page;
    logic skip;
    logic discard;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [DEPTH-1:0][PC_W-1:0] stk;
    logic [NIB_W-1:0] acc;
    logic [NIB_W-1:0] rb;
    logic [NIB_W-1:0] rc;
    logic done_flag;
    logic start;
    logic [PC_W-1:0] addr;
  } core_t;

endpackage

// ==== rtl/decode_if.sv ====
interface decode_if;
  import exec_pkg::*;
  logic [WORD_W-1:0] word;
  op_t op;
  modport dec (input word, output op);
  modport user (output word, input op);
endinterface

// ==== rtl/instr_decode.sv ====
module instr_decode (
  decode_if.dec bus
);
  import exec_pkg::*;

  always_comb begin
    case (bus.word)
      OPC_NOP: bus.op = OP_NOP;
      OPC_BEGIN_CONV: bus.op = OP_BEGIN_CONV;
      OPC_ACC_TO_C: bus.op = OP_ACC_TO_C;
      OPC_SKIP_DONE: bus.op = OP_SKIP_DONE;
      OPC_RES_HIGH: bus.op = OP_RES_HIGH;
      OPC_RES_LOW: bus.op = OP_RES_LOW;
      OPC_JUMP_IDX: bus.op = OP_JUMP_IDX;
      OPC_CALL_IDX: bus.op = OP_CALL_IDX;
      default: begin
        if ((bus.word & PAGE_MASK) == OPG_TABLE) begin
          bus.op = OP_TABLE;
        end else if ((bus.word & PAGE_MASK) == OPG_JUMP) begin
          bus.op = OP_JUMP;
        end else if ((bus.word & PAGE_MASK) == OPG_CALL) begin
          bus.op = OP_CALL;
        end else begin
          bus.op = OP_OTHER;
        end
      end
    endcase
  end
endmodule

// ==== rtl/adc_branch_exec.sv ====
module adc_branch_exec (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [exec_pkg::WORD_W-1:0] rom_data,
  input wire logic [exec_pkg::NIB_W-1:0] reg_d,
  input wire logic [exec_pkg::NIB_W-1:0] result_upper,
  input wire logic [exec_pkg::NIB_W-1:0] result_lower,
  input wire logic conversion_done,
  output logic [exec_pkg::PC_W-1:0] rom_addr_q,
  output logic [exec_pkg::PC_W-1:0] pc_q,
  output logic [exec_pkg::SP_W-1:0] stack_pointer_q,
  output logic [exec_pkg::NIB_W-1:0] acc_q,
  output logic [exec_pkg::NIB_W-1:0] reg_b_q,
  output logic [exec_pkg::NIB_W-1:0] reg_c_q,
  output logic conversion_done_flag_q,
  output logic begin_conversion_q
);
  import exec_pkg::*;

  core_t s_q;
  core_t s_d;
  op_t op;
  decode_if dif ();

  assign dif.word = rom_data;
  assign op = dif.op;

  instr_decode u_dec (
    .bus(dif.dec)
  );

  function automatic logic two_word(input op_t o);
    two_word = (o == OP_JUMP) || (o == OP_JUMP_IDX) || (o == OP_CALL) || (o == OP_CALL_IDX);
  endfunction

  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] p);
    pc_inc = PC_W'(p + 1'b1);
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    case (s_q.st)
      ST_FETCH: begin
        // ROM is read asynchronously from the registered address
        s_d.addr = s_q.pc;
        s_d.pc = pc_inc(s_q.pc);
        s_d.st = ST_EXEC;
      end
      ST_EXEC: begin
        s_d.st = ST_FETCH;
        s_d.op = op;
        s_d.page = rom_data[PAGE_W-1:0];
        if (s_q.skip) begin
          // A skipped two-word instruction loses its second word too
          s_d.skip = 1'b0;
          if (two_word(op)) begin
            s_d.discard = 1'b1;
            s_d.st = ST_FETCH2;
          end
        end else begin
          case (op)
            OP_SKIP_DONE: begin
              if (s_q.done_flag) begin
                s_d.skip = 1'b1;
                s_d.done_flag = 1'b0;
              end
            end
            OP_ACC_TO_C: s_d.rc = s_q.acc;
            OP_RES_HIGH: s_d.acc = result_upper;
            OP_RES_LOW: s_d.acc = result_lower;
            OP_BEGIN_CONV: begin
              s_d.done_flag = 1'b0;
              s_d.start = 1'b1;
            end
            OP_TABLE: begin
              s_d.stk[s_q.sp] = s_q.pc;
              s_d.sp = SP_W'(s_q.sp + 1'b1);
              s_d.st = ST_TBL_ADDR;
            end
            OP_JUMP, OP_JUMP_IDX, OP_CALL, OP_CALL_IDX: s_d.st = ST_FETCH2;
            default: ;
          endcase
        end
      end
      ST_FETCH2: begin
        s_d.addr = s_q.pc;
        s_d.pc = pc_inc(s_q.pc);
        s_d.st = ST_EXEC2;
      end
      ST_EXEC2: begin
        s_d.st = ST_FETCH;
        s_d.discard = 1'b0;
        if (!s_q.discard) begin
          case (s_q.op)
            OP_JUMP: s_d.pc = {s_q.page, rom_data[OFS_W-1:0]};
            OP_JUMP_IDX: s_d.pc = {rom_data[PAGE_W-1:0], rom_data[OFS_W-1:NIB_W], s_q.acc};
            OP_CALL: begin
              s_d.stk[s_q.sp] = s_q.pc;
              s_d.sp = SP_W'(s_q.sp + 1'b1);
              s_d.pc = {s_q.page, rom_data[OFS_W-1:0]};
            end
            OP_CALL_IDX: begin
              s_d.stk[s_q.sp] = s_q.pc;
              s_d.sp = SP_W'(s_q.sp + 1'b1);
              s_d.pc = {rom_data[PAGE_W-1:0], rom_data[OFS_W-1:NIB_W], s_q.acc};
            end
            default: ;
          endcase
        end
      end
      ST_TBL_ADDR: begin
        s_d.addr = {TBL_PAGE_TOP, s_q.page[TBL_PAGE_LO_W-1:0], reg_d[TBL_D_W-1:0], s_q.acc};
        s_d.st = ST_TBL_DATA;
      end
      ST_TBL_DATA: begin
        s_d.rb = rom_data[TBL_HI_MSB:NIB_W];
        s_d.acc = rom_data[NIB_W-1:0];
        s_d.st = ST_RESTORE;
      end
      ST_RESTORE: begin
        s_d.sp = SP_W'(s_q.sp - 1'b1);
        s_d.pc = s_q.stk[SP_W'(s_q.sp - 1'b1)];
        s_d.st = ST_RESTORE2;
      end
      ST_RESTORE2: s_d.st = ST_FETCH;
      default: s_d.st = ST_FETCH;
    endcase
    // A completion landing on a clear still leaves the flag set
    if (conversion_done) begin
      s_d.done_flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{st: ST_FETCH, op: OP_NOP, page: NIB_RESET, skip: 1'b0, discard: 1'b0,
               pc: PC_RESET, sp: SP_RESET, stk: '0, acc: NIB_RESET, rb: NIB_RESET,
               rc: NIB_RESET, done_flag: 1'b0, start: 1'b0, addr: PC_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign rom_addr_q = s_q.addr;
  assign pc_q = s_q.pc;
  assign stack_pointer_q = s_q.sp;
  assign acc_q = s_q.acc;
  assign reg_b_q = s_q.rb;
  assign reg_c_q = s_q.rc;
  assign conversion_done_flag_q = s_q.done_flag;
  assign begin_conversion_q = s_q.start;

  logic live;
  assign live = (s_q.st == ST_EXEC) && !s_q.skip;

  AST_SKIP_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
    live && op == OP_SKIP_DONE && s_q.done_flag && !conversion_done |=>
    s_q.skip && !s_q.done_flag ##2 !s_q.skip)
    else $error("done flag skip or clear wrong");
  AST_ACC_TO_C: assert property (@(posedge ref_clk) disable iff (rst)
    live && op == OP_ACC_TO_C |=> s_q.rc == $past(s_q.acc) && s_q.acc == $past(s_q.acc))
    else $error("acc to C copy wrong");
  AST_RES_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
    live && op == OP_RES_HIGH |=> s_q.acc == $past(result_upper))
    else $error("upper result not loaded");
  AST_RES_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    live && op == OP_RES_LOW |=> s_q.acc == $past(result_lower))
    else $error("lower result not loaded");
  AST_BEGIN_CONV: assert property (@(posedge ref_clk) disable iff (rst)
    live && op == OP_BEGIN_CONV && !conversion_done |=> begin_conversion_q && !s_q.done_flag ##1 !begin_conversion_q)
    else $error("conversion start wrong");
  AST_TBL_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.st == ST_TBL_ADDR |=>
    rom_addr_q == {TBL_PAGE_TOP, $past(s_q.page[TBL_PAGE_LO_W-1:0]), $past(reg_d[TBL_D_W-1:0]), $past(s_q.acc)})
    else $error("table address wrong");
  AST_TBL_DATA: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.st == ST_TBL_DATA |=>
    reg_b_q == $past(rom_data[TBL_HI_MSB:NIB_W]) && acc_q == $past(rom_data[NIB_W-1:0]))
    else $error("table data split wrong");
  AST_TBL_LEN: assert property (@(posedge ref_clk) disable iff (rst)
    live && op == OP_TABLE |=> stack_pointer_q == SP_W'($past(stack_pointer_q) + 1'b1)
    ##4 s_q.st == ST_FETCH && pc_q == $past(pc_q, 5) && stack_pointer_q == $past(stack_pointer_q, 5))
    else $error("table lookup timing or stack wrong");
  // Two machine cycles: the first word executed three edges before the jump lands
  AST_JUMP: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.st == ST_EXEC2 && !s_q.discard && s_q.op == OP_JUMP |=>
    pc_q == {$past(s_q.page), $past(rom_data[OFS_W-1:0])} && $past(s_q.st, 3) == ST_EXEC)
    else $error("long jump target wrong");
  AST_JUMP_IDX: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.st == ST_EXEC2 && !s_q.discard && s_q.op == OP_JUMP_IDX |=>
    pc_q == {$past(rom_data[PAGE_W-1:0]), $past(rom_data[OFS_W-1:NIB_W]), acc_q})
    else $error("indexed jump target wrong");
  AST_CALL: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.st == ST_EXEC2 && !s_q.discard && s_q.op == OP_CALL |=>
    stack_pointer_q == SP_W'($past(stack_pointer_q) + 1'b1) && s_q.stk[$past(stack_pointer_q)] == $past(pc_q)
    && pc_q == {$past(s_q.page), $past(rom_data[OFS_W-1:0])})
    else $error("long call push or target wrong");
  AST_CALL_IDX: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.st == ST_EXEC2 && !s_q.discard && s_q.op == OP_CALL_IDX |=>
    stack_pointer_q == SP_W'($past(stack_pointer_q) + 1'b1) && s_q.stk[$past(stack_pointer_q)] == $past(pc_q)
    && pc_q == {$past(rom_data[PAGE_W-1:0]), $past(rom_data[OFS_W-1:NIB_W]), acc_q})
    else $error("indexed call wrong");
  AST_NOP: assert property (@(posedge ref_clk) disable iff (rst)
    live && op == OP_NOP |=> $stable(acc_q) && $stable(reg_b_q) && $stable(reg_c_q) && $stable(stack_pointer_q))
    else $error("no-operation changed state");

  COV_SKIP: cover property (@(posedge ref_clk) disable iff (rst) live && op == OP_SKIP_DONE && s_q.done_flag);
  COV_TABLE: cover property (@(posedge ref_clk) disable iff (rst) s_q.st == ST_RESTORE2);
  COV_CALL: cover property (@(posedge ref_clk) disable iff (rst) s_q.st == ST_EXEC2 && s_q.op == OP_CALL_IDX);
  COV_START: cover property (@(posedge ref_clk) disable iff (rst) begin_conversion_q);
  COV_SKIP2: cover property (@(posedge ref_clk) disable iff (rst) s_q.st == ST_EXEC2 && s_q.discard);
endmodule

// ==== tb/adc_and_paged_branch_exec_tb_top.sv ====
module adc_and_paged_branch_exec_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import exec_pkg::*;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [WORD_W-1:0] rom_data;
  logic [NIB_W-1:0] reg_d = 4'h0;
  logic [NIB_W-1:0] result_upper = 4'h0;
  logic [NIB_W-1:0] result_lower = 4'h0;
  logic conversion_done = 1'b0;
  logic [PC_W-1:0] rom_addr_q;
  logic [PC_W-1:0] pc_q;
  logic [SP_W-1:0] stack_pointer_q;
  logic [NIB_W-1:0] acc_q;
  logic [NIB_W-1:0] reg_b_q;
  logic [NIB_W-1:0] reg_c_q;
  logic conversion_done_flag_q;
  logic begin_conversion_q;
  logic [WORD_W-1:0] rom [2048];
  int err_total = 0;
  int n_tests = 0;

  // Asynchronous ROM: the word follows the registered address
  assign rom_data = rom[rom_addr_q];

  always #12.5 ref_clk = ~ref_clk;

  adc_branch_exec u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .rom_data(rom_data),
    .reg_d(reg_d),
    .result_upper(result_upper),
    .result_lower(result_lower),
    .conversion_done(conversion_done),
    .rom_addr_q(rom_addr_q),
    .pc_q(pc_q),
    .stack_pointer_q(stack_pointer_q),
    .acc_q(acc_q),
    .reg_b_q(reg_b_q),
    .reg_c_q(reg_c_q),
    .conversion_done_flag_q(conversion_done_flag_q),
    .begin_conversion_q(begin_conversion_q)
  );

  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [PC_W-1:0] exp, logic [PC_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Leaves the bench 1 ns after the n-th edge, so outputs have settled
  task automatic clk_n(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Called at a rising edge; afterwards clk_n(k) lands just after edge k of the program
  task automatic boot();
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
  endtask

  task automatic clr();
    foreach (rom[i]) rom[i] = '0;
  endtask

  task automatic s_moves();
    clr();
    rom[0] = OPC_RES_HIGH;
    rom[1] = OPC_ACC_TO_C;
    rom[2] = OPC_RES_LOW;
    @(posedge ref_clk);
    result_upper <= 4'h9;
    result_lower <= 4'h6;
    boot();
    clk_n(4);
    chk("acc after move to c", 11'h009, acc_q);
    chk("c", 11'h009, reg_c_q);
    clk_n(4);
    chk("acc low result", 11'h006, acc_q);
    chk("c kept", 11'h009, reg_c_q);
    chk("b kept", 11'h000, reg_b_q);
    chk("sp kept", 11'h000, stack_pointer_q);
    chk("pc after no-op", 11'h004, pc_q);
    clk_n(1);
    chk("next fetch", 11'h004, rom_addr_q);
  endtask

  task automatic s_adc();
    clr();
    rom[1] = OPC_BEGIN_CONV;
    rom[4] = OPC_SKIP_DONE;
    // The skipped jump's second word would load the accumulator if it ran
    rom[5] = OPG_JUMP | 9'h003;
    rom[6] = OPC_RES_HIGH;
    rom[7] = OPC_SKIP_DONE;
    rom[8] = OPC_RES_HIGH;
    @(posedge ref_clk);
    result_upper <= 4'h5;
    boot();
    @(posedge ref_clk) conversion_done <= 1'b1;
    @(posedge ref_clk) conversion_done <= 1'b0;
    clk_n(1);
    chk("flag set", 11'h001, conversion_done_flag_q);
    clk_n(1);
    chk("start pulse", 11'h001, begin_conversion_q);
    chk("flag cleared by start", 11'h000, conversion_done_flag_q);
    clk_n(1);
    chk("start pulse width", 11'h000, begin_conversion_q);
    @(posedge ref_clk) conversion_done <= 1'b1;
    @(posedge ref_clk) conversion_done <= 1'b0;
    clk_n(3);
    chk("flag cleared by skip", 11'h000, conversion_done_flag_q);
    clk_n(4);
    chk("pc after skipped jump", 11'h007, pc_q);
    chk("acc with skipped second word", 11'h000, acc_q);
    clk_n(4);
    chk("acc without skip", 11'h005, acc_q);
  endtask

  task automatic s_table();
    clr();
    rom[0] = OPC_RES_LOW;
    rom[1] = OPG_TABLE | 9'h00e;
    rom[11'h735] = 9'h1a7;
    @(posedge ref_clk);
    result_lower <= 4'h5;
    reg_d <= 4'hb;
    boot();
    clk_n(4);
    chk("sp pushed", 11'h001, stack_pointer_q);
    clk_n(1);
    chk("table address", 11'h735, rom_addr_q);
    clk_n(1);
    chk("b from table", 11'h00a, reg_b_q);
    chk("acc from table", 11'h007, acc_q);
    clk_n(1);
    chk("sp restored", 11'h000, stack_pointer_q);
    chk("pc restored", 11'h002, pc_q);
    clk_n(2);
    chk("fetch after lookup", 11'h002, rom_addr_q);
  endtask

  task automatic s_branch();
    clr();
    rom[0] = OPC_RES_LOW;
    rom[1] = OPG_JUMP | 9'h003;
    rom[2] = 9'h095;
    rom[11'h195] = OPC_JUMP_IDX;
    rom[11'h196] = 9'h0a5;
    rom[11'h2ac] = OPG_CALL | 9'h006;
    rom[11'h2ad] = 9'h0b1;
    rom[11'h331] = OPC_CALL_IDX;
    rom[11'h332] = 9'h0d7;
    @(posedge ref_clk);
    result_lower <= 4'hc;
    boot();
    clk_n(3);
    chk("jump fetch", 11'h001, rom_addr_q);
    clk_n(4);
    chk("long jump target", 11'h195, rom_addr_q);
    clk_n(4);
    chk("indexed jump target", 11'h2ac, rom_addr_q);
    clk_n(4);
    chk("call target", 11'h331, rom_addr_q);
    chk("call sp", 11'h001, stack_pointer_q);
    clk_n(4);
    chk("indexed call target", 11'h3dc, rom_addr_q);
    chk("indexed call sp", 11'h002, stack_pointer_q);
  endtask

  // Guards against a hang anywhere in the sequence
  initial begin
    #100us;
    err_total++;
    tally_and_finish();
  end

  initial begin
    s_moves();
    s_adc();
    s_table();
    s_branch();
    tally_and_finish();
  end
endmodule
